// ==== rtl/tsn_pkg.sv ====
// Package for the terminal status notify word block
package tsn_pkg;
   // Register byte addresses (own choice, AXI4-Lite)
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_PERIOD = 8'h10;
   // Status word field positions
   localparam int BIT_RUN = 15;
   localparam int BIT_SCREEN = 12;
   localparam int BIT_NUMERAL = 11;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // Control register fields
   localparam int CTRL_RUN_MODE = 0;
   localparam int CTRL_MENU = 1;
   // Interrupt status fields
   localparam int IRQ_WRITE_DONE = 0;
   localparam int IRQ_HOST_CLEAR = 1;
   localparam int IRQ_RUN_LOST = 2;
   localparam int IRQ_W = 3;
   // Heartbeat refresh time in microseconds, clock rate in MHz
   localparam int REFRESH_US = 1000000;
   localparam int CLK_MHZ = 125;
   localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_WAIT
   } tsn_wstate_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } tsn_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tsn_axi_rsp_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } tsn_link_wr_t;
endpackage

// ==== rtl/tsn_status_word.sv ====
// Terminal status notify word generator with AXI4-Lite registers
`timescale 1ns/1ps
module tsn_status_word #(
   parameter int REFRESH_CYCLES = tsn_pkg::REFRESH_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire tsn_pkg::tsn_axi_req_t axi_req,
   output tsn_pkg::tsn_axi_rsp_t axi_rsp,
   input wire logic screen_changed,
   input wire logic numeral_entered,
   input wire logic host_clear,
   output tsn_pkg::tsn_link_wr_t link_wr,
   input wire logic link_ack,
   output logic irq
);
   typedef struct packed {
      logic [15:0] word;
      logic [15:0] sent;
      logic run_mode;
      logic menu;
      logic [tsn_pkg::IRQ_W-1:0] istat;
      logic [tsn_pkg::IRQ_W-1:0] imask;
      logic [31:0] period;
      logic [31:0] cnt;
      logic refresh;
      tsn_pkg::tsn_wstate_t wst;
      tsn_pkg::tsn_link_wr_t lw;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tsn_state_t;

   tsn_state_t s_q;
   tsn_state_t s_d;

   // Five word registers; any other offset answers SLVERR with no effect
   function automatic logic is_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         tsn_pkg::ADDR_STATUS: begin
            hit = 1'b1;
         end
         tsn_pkg::ADDR_CTRL: begin
            hit = 1'b1;
         end
         tsn_pkg::ADDR_IRQ_STAT: begin
            hit = 1'b1;
         end
         tsn_pkg::ADDR_IRQ_MASK: begin
            hit = 1'b1;
         end
         tsn_pkg::ADDR_PERIOD: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // Only the three notified fields survive; all other bits go out as zero
   function automatic logic [15:0] pack_status(input logic [15:0] w);
      logic [15:0] p;
      p = tsn_pkg::STATUS_RESET;
      p[tsn_pkg::BIT_RUN] = w[tsn_pkg::BIT_RUN];
      p[tsn_pkg::BIT_SCREEN] = w[tsn_pkg::BIT_SCREEN];
      p[tsn_pkg::BIT_NUMERAL] = w[tsn_pkg::BIT_NUMERAL];
      return p;
   endfunction

   // Last cycle of the refresh interval
   function automatic logic period_done(input logic [31:0] cnt,
                                        input logic [31:0] period);
      return cnt >= period - 32'h1;
   endfunction

   // Clears only the strobes that the delivered word actually carried
   function automatic logic [15:0] strobe_clear(input logic [15:0] w,
                                                input logic [15:0] sent);
      logic [15:0] r;
      r = w;
      if (sent[tsn_pkg::BIT_SCREEN]) begin
         r[tsn_pkg::BIT_SCREEN] = 1'b0;
      end
      if (sent[tsn_pkg::BIT_NUMERAL]) begin
         r[tsn_pkg::BIT_NUMERAL] = 1'b0;
      end
      return r;
   endfunction

   // Read-back word for one offset; unused bits read as zero
   function automatic logic [31:0] rd_word(input logic [7:0] a,
      input logic [15:0] status, input logic run_mode, input logic menu,
      input logic [tsn_pkg::IRQ_W-1:0] istat,
      input logic [tsn_pkg::IRQ_W-1:0] imask, input logic [31:0] period);
      logic [31:0] r;
      r = '0;
      case (a)
         tsn_pkg::ADDR_STATUS: begin
            r = {16'h0000, status};
         end
         tsn_pkg::ADDR_CTRL: begin
            r[tsn_pkg::CTRL_RUN_MODE] = run_mode;
            r[tsn_pkg::CTRL_MENU] = menu;
         end
         tsn_pkg::ADDR_IRQ_STAT: begin
            r[tsn_pkg::IRQ_W-1:0] = istat;
         end
         tsn_pkg::ADDR_IRQ_MASK: begin
            r[tsn_pkg::IRQ_W-1:0] = imask;
         end
         tsn_pkg::ADDR_PERIOD: begin
            r = period;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   logic running;
   logic [15:0] live;
   logic rd_fire;
   logic wr_fire;
   logic [31:0] wr_val;
   // Interrupt events of this cycle and bits cleared by a status read
   logic [tsn_pkg::IRQ_W-1:0] ev;
   logic [tsn_pkg::IRQ_W-1:0] rd_clr;

   always_comb begin
      running = s_q.run_mode && !s_q.menu;
      live = pack_status(s_q.word);
      wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      rd_fire = axi_req.arvalid && !s_q.rvalid;
      wr_val = s_q.wdata;
   end

   always_comb begin
      s_d = s_q;
      ev = '0;
      rd_clr = '0;

      // Host clear comes first so that a refresh in the same cycle wins
      if (host_clear && s_q.word[tsn_pkg::BIT_RUN]) begin
         s_d.word[tsn_pkg::BIT_RUN] = 1'b0;
         s_d.sent[tsn_pkg::BIT_RUN] = 1'b0;
         ev[tsn_pkg::IRQ_HOST_CLEAR] = 1'b1;
      end

      // Run indicator follows mode; host may clear it until the refresh
      if (!running) begin
         s_d.word[tsn_pkg::BIT_RUN] = 1'b0;
         s_d.cnt = '0;
      end else begin
         if (period_done(s_q.cnt, s_q.period)) begin
            s_d.cnt = '0;
            s_d.refresh = 1'b1;
            s_d.word[tsn_pkg::BIT_RUN] = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 32'h1;
         end
         if (!s_q.word[tsn_pkg::BIT_RUN] && s_q.cnt == '0 &&
            !s_q.refresh) begin
            s_d.word[tsn_pkg::BIT_RUN] = 1'b1;
         end
      end

      if (running && s_q.word[tsn_pkg::BIT_RUN] == 1'b0 &&
         s_q.sent[tsn_pkg::BIT_RUN]) begin
         ev[tsn_pkg::IRQ_RUN_LOST] = 1'b1;
      end

      // Link write machine
      case (s_q.wst)
         tsn_pkg::ST_IDLE: begin
            if (running && s_q.word[tsn_pkg::BIT_RUN] &&
               (live != s_q.sent || s_q.refresh)) begin
               s_d.lw.valid = 1'b1;
               s_d.lw.data = live;
               s_d.refresh = 1'b0;
               s_d.wst = tsn_pkg::ST_WRITE;
            end
         end
         tsn_pkg::ST_WRITE: begin
            if (link_ack) begin
               s_d.lw.valid = 1'b0;
               s_d.sent = s_q.lw.data;
               ev[tsn_pkg::IRQ_WRITE_DONE] = 1'b1;
               // Delivered strobes clear
               s_d.word = strobe_clear(s_d.word, s_q.lw.data);
               s_d.wst = tsn_pkg::ST_WAIT;
            end
         end
         tsn_pkg::ST_WAIT: begin
            s_d.wst = tsn_pkg::ST_IDLE;
         end
         default: begin
            s_d.wst = tsn_pkg::ST_IDLE;
         end
      endcase
      // New events win over delivery clear
      if (screen_changed) begin
         s_d.word[tsn_pkg::BIT_SCREEN] = 1'b1;
      end
      if (numeral_entered) begin
         s_d.word[tsn_pkg::BIT_NUMERAL] = 1'b1;
      end
      // AXI write channels
      if (axi_req.awvalid && !s_q.aw_got) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_q.w_got) begin
         s_d.w_got = 1'b1;
         s_d.wdata = axi_req.wdata;
         s_d.wstrb = axi_req.wstrb;
      end
      if (wr_fire) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = is_mapped(s_q.awaddr) ? tsn_pkg::RESP_OKAY :
            tsn_pkg::RESP_SLVERR;
         case (s_q.awaddr)
            tsn_pkg::ADDR_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.run_mode = wr_val[tsn_pkg::CTRL_RUN_MODE];
                  s_d.menu = wr_val[tsn_pkg::CTRL_MENU];
               end
            end
            tsn_pkg::ADDR_IRQ_MASK: begin
               if (s_q.wstrb[0]) begin
                  s_d.imask = wr_val[tsn_pkg::IRQ_W-1:0];
               end
            end
            tsn_pkg::ADDR_PERIOD: begin
               // A zero period would stall the refresh, so it is ignored
               if (s_q.wstrb == 4'hF && wr_val != '0) begin
                  s_d.period = wr_val;
               end
            end
            default: begin
            end
         endcase
      end

      if (s_q.bvalid && axi_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      // AXI read channel; reading the interrupt status clears it
      if (rd_fire) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = is_mapped(axi_req.araddr) ? tsn_pkg::RESP_OKAY :
            tsn_pkg::RESP_SLVERR;
         s_d.rdata = rd_word(axi_req.araddr, live, s_q.run_mode, s_q.menu,
            s_q.istat, s_q.imask, s_q.period);
         if (axi_req.araddr == tsn_pkg::ADDR_IRQ_STAT) begin
            rd_clr = s_q.istat;
         end
      end
      if (s_q.rvalid && axi_req.rready) begin
         s_d.rvalid = 1'b0;
      end

      // Sticky status: an event in the cycle of the clearing read wins
      s_d.istat = (s_q.istat & ~rd_clr) | ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.period <= 32'(REFRESH_CYCLES);
         s_q.wst <= tsn_pkg::ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Ready outputs and irq are combinational, everything else comes from flops
   always_comb begin
      axi_rsp.awready = !s_q.aw_got;
      axi_rsp.wready = !s_q.w_got;
      axi_rsp.bvalid = s_q.bvalid;
      axi_rsp.bresp = s_q.bresp;
      axi_rsp.arready = !s_q.rvalid;
      axi_rsp.rvalid = s_q.rvalid;
      axi_rsp.rdata = s_q.rdata;
      axi_rsp.rresp = s_q.rresp;
      link_wr = s_q.lw;
      irq = |(s_q.istat & s_q.imask);
   end
endmodule // tsn_status_word

// ==== sim/tb_top.sv ====
// Self-checking bench for the status word block
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn, scr, num, hclr, ack, irq, slow, check, alive, done;
   logic [15:0] mem, seen;
   tsn_pkg::tsn_axi_req_t req;
   tsn_pkg::tsn_axi_rsp_t rsp;
   tsn_pkg::tsn_link_wr_t lw;
   int n_mismatch = 0;
   int num_checks = 0;
   always #4 aclk = ~aclk;
   tsn_status_word #(.REFRESH_CYCLES(16)) dut (.aclk(aclk), .aresetn(aresetn),
      .axi_req(req), .axi_rsp(rsp), .screen_changed(scr),
      .numeral_entered(num), .host_clear(hclr), .link_wr(lw),
      .link_ack(ack), .irq(irq));
   tsn_host_model host (.aclk(aclk), .aresetn(aresetn), .link_wr(lw),
      .link_ack(ack), .host_clear(hclr), .slow(slow), .check(check),
      .mem_q(mem), .seen_q(seen), .alive(alive), .done(done));
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic lim(input int n);
      if (n >= 200) begin
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int n = 0;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      while (n < 200) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
         n++;
      end
      lim(n);
      chk({30'h0, rsp.bresp}, {30'h0, er});
      req.bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
      int n = 0;
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      while (n < 200) begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
         n++;
      end
      lim(n);
      d = rsp.rdata;
      chk({30'h0, rsp.rresp}, {30'h0, er});
      req.rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wt(input logic [15:0] s);
      int n = 0;
      while ((seen !== s || mem !== 16'h8000) && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk({16'h0, seen, mem}, {16'h0, s, 16'h8000});
      lim(n);
   endtask
   task automatic live(input logic exp);
      int n = 0;
      check <= 1'b1;
      @(posedge aclk);
      check <= 1'b0;
      @(posedge aclk);
      while (!done && n < 200) begin
         @(posedge aclk);
         n++;
      end
      lim(n);
      chk({31'h0, alive}, {31'h0, exp});
   endtask
   task automatic t_regs();
      logic [31:0] d;
      axr(tsn_pkg::ADDR_CTRL, tsn_pkg::RESP_OKAY, d);
      chk(d, 32'h0);
      axr(tsn_pkg::ADDR_PERIOD, tsn_pkg::RESP_OKAY, d);
      chk(d, 32'h10);
      axr(8'h14, tsn_pkg::RESP_SLVERR, d);
      axw(8'h14, 32'h1, tsn_pkg::RESP_SLVERR);
      axr(tsn_pkg::ADDR_STATUS, tsn_pkg::RESP_OKAY, d);
      chk(d, 32'h0);
      axw(tsn_pkg::ADDR_CTRL, 32'h1, tsn_pkg::RESP_OKAY);
      wt(16'h8000);
   endtask
   task automatic t_events();
      scr <= 1'b1;
      @(posedge aclk);
      scr <= 1'b0;
      wt(16'h9000);
      slow <= 1'b1;
      num <= 1'b1;
      @(posedge aclk);
      num <= 1'b0;
      wt(16'h9800);
   endtask
   task automatic t_live();
      logic [31:0] d;
      axw(tsn_pkg::ADDR_IRQ_MASK, 32'h2, tsn_pkg::RESP_OKAY);
      live(1'b1);
      chk({31'h0, irq}, 32'h1);
      axr(tsn_pkg::ADDR_IRQ_STAT, tsn_pkg::RESP_OKAY, d);
      chk(d & 32'h2, 32'h2);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_menu();
      logic [31:0] d;
      axw(tsn_pkg::ADDR_CTRL, 32'h3, tsn_pkg::RESP_OKAY);
      axr(tsn_pkg::ADDR_STATUS, tsn_pkg::RESP_OKAY, d);
      chk(d, 32'h0);
      live(1'b0);
   endtask
   initial begin
      req = '0;
      {aresetn, scr, num, slow, check} = 5'h00;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_events();
      t_live();
      t_menu();
      summarize();
   end
endmodule // tb_top

// ==== sim/tsn_host_model.sv ====
// Host controller model: keeps the delivered word, runs the liveness test
`timescale 1ns/1ps
module tsn_host_model #(
   parameter int WINDOW = 40
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire tsn_pkg::tsn_link_wr_t link_wr,
   output logic link_ack,
   output logic host_clear,
   input wire logic slow,
   input wire logic check,
   output logic [15:0] mem_q,
   output logic [15:0] seen_q,
   output logic alive,
   output logic done
);
   int wait_q;
   int win_q;
   // One word only, so it never overlaps a control word
   always @(posedge aclk) begin
      host_clear <= 1'b0;
      if (!aresetn) begin
         link_ack <= 1'b0;
         mem_q <= 16'h0000;
         seen_q <= 16'h0000;
         wait_q <= 0;
         win_q <= 0;
         done <= 1'b0;
         alive <= 1'b0;
      end else begin
         if (link_wr.valid && link_ack) begin
            mem_q <= link_wr.data;
            seen_q <= seen_q | link_wr.data;
            link_ack <= 1'b0;
            wait_q <= 0;
         end else if (link_wr.valid) begin
            wait_q <= wait_q + 1;
            link_ack <= wait_q >= (slow ? 3 : 0);
         end
         if (check) begin
            host_clear <= 1'b1;
            mem_q[15] <= 1'b0;
            win_q <= WINDOW;
            done <= 1'b0;
         end else if (win_q == 1) begin
            alive <= mem_q[15];
            done <= 1'b1;
            win_q <= 0;
         end else if (win_q > 0) begin
            win_q <= win_q - 1;
         end
      end
   end
endmodule // tsn_host_model

// ==== sim/tsn_monitor.sv ====
// Port checker for the status word block
`timescale 1ns/1ps
module tsn_monitor #(
   parameter int REFRESH_CYCLES = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire tsn_pkg::tsn_axi_req_t axi_req,
   input wire tsn_pkg::tsn_axi_rsp_t axi_rsp,
   input wire logic screen_changed,
   input wire logic numeral_entered,
   input wire logic host_clear,
   input wire tsn_pkg::tsn_link_wr_t link_wr,
   input wire logic link_ack,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic v = link_wr.valid;
   spare_zero_a: assert property (v |-> !(link_wr.data & 16'h67FF))
      else $error("spare status bits set");
   run_gate_a: assert property (v |-> link_wr.data[15])
      else $error("write with run bit clear");
   word_hold_a: assert property (v && !link_ack |=> v && $stable(link_wr.data))
      else $error("word not held until taken");
   ack_drop_a: assert property (v && link_ack |=> !v)
      else $error("write kept after ack");
   scr_clr_a: assert property (v && link_ack && link_wr.data[12] &&
      !screen_changed ##1 !screen_changed |=> !(v && link_wr.data[12]))
      else $error("screen strobe not cleared");
   num_clr_a: assert property (v && link_ack && link_wr.data[11] &&
      !numeral_entered ##1 !numeral_entered |=> !(v && link_wr.data[11]))
      else $error("numeral strobe not cleared");
   b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
      else $error("write response dropped");
   r_ans_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
endmodule // tsn_monitor

bind tsn_status_word tsn_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_mon (
   .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .screen_changed(screen_changed), .numeral_entered(numeral_entered),
   .host_clear(host_clear), .link_wr(link_wr), .link_ack(link_ack), .irq(irq));
